// ### cis_pkg.sv
package cis_pkg;
    // apb register offsets (byte addresses)
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_ISTAT  = 8'h08;
    localparam logic [7:0] OFS_IMASK  = 8'h0c;
    localparam logic [7:0] OFS_STATE  = 8'h10;

    // flag bit positions
    localparam int NFLAG     = 12;
    localparam int F_EXT1    = 0;
    localparam int F_EXT2    = 1;
    localparam int F_TUF     = 2;
    localparam int F_CAPT    = 3;
    localparam int F_CMP     = 4;
    localparam int F_T1OVF   = 5;
    localparam int F_SPI     = 6;
    localparam int F_ENCEMP  = 7;
    localparam int F_ENCDONE = 8;
    localparam int F_DECFULL = 9;
    localparam int F_DECOVR  = 10;
    localparam int F_KEY     = 11;

    // reset values
    localparam logic [11:0] ENABLE_RST = 12'h000;
    localparam logic [2:0]  IMASK_RST  = 3'h0;

    // sticky event bits
    localparam int NEVT    = 3;
    localparam int E_HWINT = 0;
    localparam int E_SWI   = 1;
    localparam int E_RTI   = 2;

    // condition code layout
    localparam int CCR_I_BIT = 3;

    // index of the last stack frame byte (frame is five bytes)
    localparam logic [2:0] FRAME_LAST = 3'h4;

    // vector pairs (address of high byte)
    localparam logic [15:0] VEC_RESET  = 16'hfffe;
    localparam logic [15:0] VEC_SWI    = 16'hfffc;
    localparam logic [15:0] VEC_EXT    = 16'hfffa;
    localparam logic [15:0] VEC_TIMER2 = 16'hfff8;
    localparam logic [15:0] VEC_TIMER1 = 16'hfff6;
    localparam logic [15:0] VEC_SERIAL = 16'hfff4;
    localparam logic [15:0] VEC_CODER  = 16'hfff2;
    localparam logic [15:0] VEC_KEYPAD = 16'hfff0;

    typedef enum logic [2:0] {
        GRP_EXT, GRP_TIMER2, GRP_TIMER1, GRP_SERIAL, GRP_CODER, GRP_KEYPAD,
        GRP_NONE
    } cis_grp_t;
endpackage : cis_pkg

// ### cis_flag_bank.sv
`timescale 1ns/1ps
module cis_flag_bank
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // per flag set and clear
    input  wire logic [11:0] set_evt,
    input  wire logic [11:0] clr,
    // flag state
    output logic      [11:0] flags
);
    genvar g;
    generate
        for (g = 0; g < cis_pkg::NFLAG; g++)
        begin : g_flag
            // set wins over a clear in the same cycle
            always_ff @(posedge clk)
            begin
                if (srst)
                    flags[g] <= 1'b0;
                else if (set_evt[g])
                    flags[g] <= 1'b1;
                else if (clr[g])
                    flags[g] <= 1'b0;
            end
        end
    endgenerate
endmodule : cis_flag_bank

// ### cis_prio.sv
`timescale 1ns/1ps
module cis_prio
(
    // enabled pending flags
    input  wire logic [11:0]       req,
    // winning group and its vector
    output cis_pkg::cis_grp_t      grp,
    output logic      [15:0]       vec
);
    always_comb
    begin
        grp = cis_pkg::GRP_NONE;
        vec = cis_pkg::VEC_RESET;
        if (req[cis_pkg::F_EXT1] || req[cis_pkg::F_EXT2])
        begin
            grp = cis_pkg::GRP_EXT;
            vec = cis_pkg::VEC_EXT;
        end
        else if (req[cis_pkg::F_TUF])
        begin
            grp = cis_pkg::GRP_TIMER2;
            vec = cis_pkg::VEC_TIMER2;
        end
        else if (|req[cis_pkg::F_T1OVF:cis_pkg::F_CAPT])
        begin
            grp = cis_pkg::GRP_TIMER1;
            vec = cis_pkg::VEC_TIMER1;
        end
        else if (req[cis_pkg::F_SPI])
        begin
            grp = cis_pkg::GRP_SERIAL;
            vec = cis_pkg::VEC_SERIAL;
        end
        else if (|req[cis_pkg::F_DECOVR:cis_pkg::F_ENCEMP])
        begin
            grp = cis_pkg::GRP_CODER;
            vec = cis_pkg::VEC_CODER;
        end
        else if (req[cis_pkg::F_KEY])
        begin
            grp = cis_pkg::GRP_KEYPAD;
            vec = cis_pkg::VEC_KEYPAD;
        end
    end
endmodule : cis_prio

// ### cis_seq.sv
// Summary of operation
// - seven sources: six hardware groups plus the software trap instruction
// - mask bit blocks hardware requests; software trap taken regardless
// - disabled source cannot request, but its flag still sets
// - every reset clears all per-source enables
// - flags in read-only status register, enables in separate control register
// - read status with flag set, then access enable register clears it
// - pending request taken only at an instruction boundary
// - push machine state, then load pc from source vector pair
// - mask bit set after stacking
// - return instruction restores stacked state and resumes program
// - return clears mask only when stacked mask copy is zero
// - timer2 underflow uses the timer2 vector pair
// - four line coder flags share one vector
// - both external pins share one vector pair
// - timer1 capture, compare, overflow share one vector pair
// - keypad uses the lowest vector pair
// - software trap uses the pair below the reset vector
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module cis_seq
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // peripheral flag events
    input  wire logic [11:0] FLAG_EVT,
    // core sequencer inputs
    input  wire logic        INSTR_END,
    input  wire logic        SWI_EXEC,
    input  wire logic        RTI_EXEC,
    input  wire logic [15:0] CUR_PC,
    input  wire logic [7:0]  CUR_X,
    input  wire logic [7:0]  CUR_A,
    input  wire logic [7:0]  CUR_CCR,
    input  wire logic [7:0]  STK_RDATA,
    // core sequencer outputs
    output logic             BUSY,
    output logic             STK_WR,
    output logic             STK_RD,
    output logic      [7:0]  STK_WDATA,
    output logic             VEC_LOAD,
    output logic      [15:0] VEC_ADDR,
    output logic             RESTORE,
    output logic      [15:0] RST_PC,
    output logic      [7:0]  RST_X,
    output logic      [7:0]  RST_A,
    output logic      [7:0]  RST_CCR,
    output logic             I_MASK,
    // interrupt line
    output logic             IRQ
);
    typedef enum {S_IDLE, S_PUSH, S_VEC, S_POP, S_POPW, S_RESTORE} cis_st_t;

    cis_st_t           state;
    logic [2:0]        idx;
    logic [7:0]        frame [0:4];
    logic [15:0]       vec_hold;
    logic [11:0]       en;
    logic [11:0]       flags;
    logic [11:0]       armed;
    logic [11:0]       flag_clr;
    logic [11:0]       hw_req;
    logic [2:0]        istat;
    logic [2:0]        imask;
    logic [2:0]        evt;
    logic [15:0]       prio_vec;
    cis_pkg::cis_grp_t prio_grp;
    logic              apb_done;
    logic              hit_en;
    logic              hit_flags;
    logic              hit_istat;
    logic              hit_imask;
    logic              hit_state;
    logic              take_hw;
    logic              take_swi;
    logic [2:0]        pop_slot;

    assign apb_done  = PSEL && PENABLE && PREADY;
    assign hit_en    = PADDR == cis_pkg::OFS_ENABLE;
    assign hit_flags = PADDR == cis_pkg::OFS_FLAGS;
    assign hit_istat = PADDR == cis_pkg::OFS_ISTAT;
    assign hit_imask = PADDR == cis_pkg::OFS_IMASK;
    assign hit_state = PADDR == cis_pkg::OFS_STATE;

    // disabled sources never request
    assign hw_req   = flags & en;
    // software trap ignores the mask, hardware waits for a boundary
    assign take_swi = state == S_IDLE && SWI_EXEC;
    assign take_hw  = state == S_IDLE && !SWI_EXEC && INSTR_END &&
                      !I_MASK && |hw_req;
    assign pop_slot = cis_pkg::FRAME_LAST - idx;

    // flags held apart from enables
    cis_flag_bank u_flags
    (
        .clk     (CLK),
        .srst    (SRST),
        .set_evt (FLAG_EVT),
        .clr     (flag_clr),
        .flags   (flags)
    );

    // fixed priority and vector choice
    cis_prio u_prio
    (
        .req (hw_req),
        .grp (prio_grp),
        .vec (prio_vec)
    );

    // apb handshake, one wait state
    always_ff @(posedge CLK)
    begin
        if (SRST)
            PREADY <= 1'b0;
        else
            PREADY <= PSEL && PENABLE && !PREADY;
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (PSEL && PENABLE && !PREADY)
        begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= !(hit_en || hit_flags || hit_istat ||
                         hit_imask || hit_state);
            if (!PWRITE)
            begin
                if (hit_en)
                    PRDATA <= {20'h00000, en};
                else if (hit_flags)
                    PRDATA <= {20'h00000, flags};
                else if (hit_istat)
                    PRDATA <= {29'h0000_0000, istat};
                else if (hit_imask)
                    PRDATA <= {29'h0000_0000, imask};
                else if (hit_state)
                    PRDATA <= {24'h000000, 1'b0, prio_grp, 2'b00, BUSY,
                               I_MASK};
            end
        end
    end

    // enable register, cleared by every reset
    always_ff @(posedge CLK)
    begin
        if (SRST)
            en <= cis_pkg::ENABLE_RST;
        else if (apb_done && PWRITE && hit_en)
            en <= PWDATA[11:0];
    end

    // two-step flag clear: status read arms, enable access clears
    always_ff @(posedge CLK)
    begin
        if (SRST)
            armed <= 12'h000;
        else if (apb_done && !PWRITE && hit_flags)
            armed <= PRDATA[11:0];
        else if (apb_done && hit_en)
            armed <= 12'h000;
    end

    assign flag_clr = (apb_done && hit_en) ? armed : 12'h000;

    // mask register for sticky events
    always_ff @(posedge CLK)
    begin
        if (SRST)
            imask <= cis_pkg::IMASK_RST;
        else if (apb_done && PWRITE && hit_imask)
            imask <= PWDATA[2:0];
    end

    // sticky events, read clears, set wins
    assign evt[cis_pkg::E_HWINT] = take_hw;
    assign evt[cis_pkg::E_SWI]   = take_swi;
    assign evt[cis_pkg::E_RTI]   = state == S_RESTORE;

    always_ff @(posedge CLK)
    begin
        if (SRST)
            istat <= 3'h0;
        else if (apb_done && !PWRITE && hit_istat)
            istat <= (istat & ~PRDATA[2:0]) | evt;
        else
            istat <= istat | evt;
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            IRQ <= 1'b0;
        else
            IRQ <= |(istat & imask);
    end

    // entry and return sequencer
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state    <= S_IDLE;
            idx      <= 3'h0;
            vec_hold <= cis_pkg::VEC_RESET;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    idx <= 3'h0;
                    if (take_swi)
                    begin
                        state    <= S_PUSH;
                        vec_hold <= cis_pkg::VEC_SWI;
                    end
                    else if (take_hw)
                    begin
                        state    <= S_PUSH;
                        vec_hold <= prio_vec;
                    end
                    else if (RTI_EXEC)
                        state <= S_POP;
                end
                S_PUSH:
                begin
                    idx <= idx + 3'h1;
                    if (idx == cis_pkg::FRAME_LAST)
                        state <= S_VEC;
                end
                S_VEC:
                    state <= S_IDLE;
                S_POP:
                    state <= S_POPW;
                S_POPW:
                begin
                    idx <= idx + 3'h1;
                    state <= (idx == cis_pkg::FRAME_LAST) ? S_RESTORE : S_POP;
                end
                S_RESTORE:
                    state <= S_IDLE;
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    // frame image: pcl, pch, x, a, ccr
    always_ff @(posedge CLK)
    begin
        if (state == S_IDLE && (take_swi || take_hw))
        begin
            frame[0] <= CUR_PC[7:0];
            frame[1] <= CUR_PC[15:8];
            frame[2] <= CUR_X;
            frame[3] <= CUR_A;
            frame[4] <= {CUR_CCR[7:cis_pkg::CCR_I_BIT + 1], I_MASK,
                         CUR_CCR[cis_pkg::CCR_I_BIT - 1:0]};
        end
        else if (state == S_POPW)
            frame[pop_slot] <= STK_RDATA;
    end

    // stack strobes and data
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            STK_WR    <= 1'b0;
            STK_RD    <= 1'b0;
            STK_WDATA <= 8'h00;
        end
        else
        begin
            STK_WR    <= state == S_PUSH;
            STK_RD    <= state == S_POP;
            STK_WDATA <= (state == S_PUSH) ? frame[idx] : 8'h00;
        end
    end

    // vector load and restore outputs
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            VEC_LOAD <= 1'b0;
            VEC_ADDR <= cis_pkg::VEC_RESET;
            RESTORE  <= 1'b0;
            RST_PC   <= 16'h0000;
            RST_X    <= 8'h00;
            RST_A    <= 8'h00;
            RST_CCR  <= 8'h00;
            BUSY     <= 1'b0;
        end
        else
        begin
            VEC_LOAD <= state == S_VEC;
            if (state == S_VEC)
                VEC_ADDR <= vec_hold;
            RESTORE <= state == S_RESTORE;
            if (state == S_RESTORE)
            begin
                RST_PC  <= {frame[1], frame[0]};
                RST_X   <= frame[2];
                RST_A   <= frame[3];
                RST_CCR <= frame[4];
            end
            BUSY <= (state != S_IDLE && state != S_RESTORE &&
                     state != S_VEC) || take_swi || take_hw || RTI_EXEC;
        end
    end

    // global mask bit
    always_ff @(posedge CLK)
    begin
        if (SRST)
            I_MASK <= 1'b1;
        else if (state == S_VEC)
            I_MASK <= 1'b1;
        else if (state == S_RESTORE)
            I_MASK <= frame[4][cis_pkg::CCR_I_BIT];
    end

    a_en_reset: assert property (@(posedge CLK)
        SRST |=> en == 12'h000)
        else $error("enables not cleared by reset");

    a_mask_blocks_hw: assert property (@(posedge CLK) disable iff (SRST)
        (state == S_IDLE && I_MASK && !SWI_EXEC) |=> state != S_PUSH)
        else $error("hardware request taken while masked");

    a_swi_unmasked: assert property (@(posedge CLK) disable iff (SRST)
        (state == S_IDLE && SWI_EXEC) |-> ##7
        (VEC_LOAD && VEC_ADDR == cis_pkg::VEC_SWI))
        else $error("software trap vector wrong or late");

    a_boundary_only: assert property (@(posedge CLK) disable iff (SRST)
        (state == S_IDLE && !INSTR_END && !SWI_EXEC) |=> state != S_PUSH)
        else $error("hardware entry off an instruction boundary");

    a_push_then_vec: assert property (@(posedge CLK) disable iff (SRST)
        (state == S_IDLE ##1 state == S_PUSH) |-> ##1 STK_WR [*5]
        ##1 (VEC_LOAD && !STK_WR))
        else $error("stacking sequence broken");

    a_mask_after: assert property (@(posedge CLK) disable iff (SRST)
        $rose(VEC_LOAD) |-> I_MASK && $past(STK_WR))
        else $error("mask not set after stacking");

    a_timer2_vec: assert property (@(posedge CLK) disable iff (SRST)
        (take_hw && hw_req[1:0] == 2'b00 && hw_req[cis_pkg::F_TUF])
        |-> ##7 (VEC_LOAD && VEC_ADDR == cis_pkg::VEC_TIMER2))
        else $error("timer2 vector wrong");

    a_disabled_idle: assert property (@(posedge CLK) disable iff (SRST)
        (en == 12'h000 && state == S_IDLE && !SWI_EXEC) |=> state != S_PUSH)
        else $error("disabled source caused entry");

    a_flag_sets: assert property (@(posedge CLK) disable iff (SRST)
        FLAG_EVT[cis_pkg::F_KEY] |=> flags[cis_pkg::F_KEY])
        else $error("flag failed to set");

    a_two_step_clr: assert property (@(posedge CLK) disable iff (SRST)
        (flags[cis_pkg::F_SPI] && !armed[cis_pkg::F_SPI] &&
         !FLAG_EVT[cis_pkg::F_SPI]) |=> flags[cis_pkg::F_SPI])
        else $error("flag cleared without status read");

    a_rti_mask: assert property (@(posedge CLK) disable iff (SRST)
        RESTORE |-> I_MASK == RST_CCR[cis_pkg::CCR_I_BIT])
        else $error("mask not restored from stacked copy");
endmodule : cis_seq

// ### cis_core_model.sv
`timescale 1ns/1ps
module cis_core_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // stack traffic from the sequencer
    input  wire logic       stk_wr,
    input  wire logic       stk_rd,
    input  wire logic [7:0] stk_wdata,
    // pushes made by the program itself
    input  wire logic       sw_push,
    input  wire logic [7:0] sw_byte,
    // popped byte
    output logic      [7:0] stk_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] sp;
    logic [7:0] last;

    // stack grows down, sp kept here on the core side
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sp   <= 8'hff;
            last <= 8'h00;
        end
        else if (stk_wr || sw_push)
        begin
            mem[sp] <= stk_wr ? stk_wdata : sw_byte;
            sp      <= sp - 8'h01;
        end
        else if (stk_rd)
        begin
            sp   <= sp + 8'h01;
            last <= mem[sp + 8'h01];
        end
    end

    // byte only valid during a pop, inverted otherwise
    assign stk_rdata = stk_rd ? mem[sp + 8'h01] : ~last;
endmodule : cis_core_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0]  PADDR, STK_RDATA, STK_WDATA, CUR_X, CUR_A, CUR_CCR;
    logic [31:0] PWDATA, PRDATA, rd, r;
    logic [11:0] FLAG_EVT;
    logic        INSTR_END, SWI_EXEC, RTI_EXEC, BUSY, STK_WR, STK_RD;
    logic        VEC_LOAD, RESTORE, I_MASK, IRQ, sw_push, er, im;
    logic [15:0] CUR_PC, VEC_ADDR, RST_PC;
    logic [7:0]  RST_X, RST_A, RST_CCR, sw_byte;
    logic [39:0] frm_q[$];
    int          fails, comparisons, seed;

    cis_seq u_cis_seq
    (
        .CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .FLAG_EVT(FLAG_EVT),
        .INSTR_END(INSTR_END), .SWI_EXEC(SWI_EXEC), .RTI_EXEC(RTI_EXEC),
        .CUR_PC(CUR_PC), .CUR_X(CUR_X), .CUR_A(CUR_A), .CUR_CCR(CUR_CCR),
        .STK_RDATA(STK_RDATA), .BUSY(BUSY), .STK_WR(STK_WR),
        .STK_RD(STK_RD), .STK_WDATA(STK_WDATA), .VEC_LOAD(VEC_LOAD),
        .VEC_ADDR(VEC_ADDR), .RESTORE(RESTORE), .RST_PC(RST_PC),
        .RST_X(RST_X), .RST_A(RST_A), .RST_CCR(RST_CCR), .I_MASK(I_MASK),
        .IRQ(IRQ)
    );

    cis_core_model u_cis_core_model
    (
        .clk(CLK), .srst(SRST), .stk_wr(STK_WR), .stk_rd(STK_RD),
        .stk_wdata(STK_WDATA), .sw_push(sw_push), .sw_byte(sw_byte),
        .stk_rdata(STK_RDATA)
    );

    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task halt;
        fails++;
        results();
    endtask : halt

    task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1)
            halt();
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task evt(input logic [11:0] m);
        @(posedge CLK);
        FLAG_EVT <= m;
        @(posedge CLK);
        FLAG_EVT <= 12'h000;
    endtask : evt

    // boundary pulse that must not start an entry
    task no_take(input string nm);
        @(posedge CLK);
        INSTR_END <= 1'b1;
        @(posedge CLK);
        INSTR_END <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(nm, 1'b0, BUSY);
    endtask : no_take

    task automatic take(input logic software_trap_instr, input logic [15:0] v);
        logic [7:0]  got[$];
        logic [39:0] f;
        int          n;
        @(posedge CLK);
        r = $random(seed);
        CUR_PC <= r[15:0];
        CUR_X  <= r[23:16];
        CUR_A  <= r[31:24];
        r = $random(seed);
        CUR_CCR <= r[7:0];
        SWI_EXEC  <= software_trap_instr;
        INSTR_END <= ~software_trap_instr;
        @(posedge CLK);
        SWI_EXEC  <= 1'b0;
        INSTR_END <= 1'b0;
        f = {CUR_PC, CUR_X, CUR_A, CUR_CCR};
        f[cis_pkg::CCR_I_BIT] = im;
        n = 0;
        while (VEC_LOAD !== 1'b1 && n < 30)
        begin
            @(posedge CLK);
            if (STK_WR === 1'b1)
                got.push_back(STK_WDATA);
            n++;
        end
        if (VEC_LOAD !== 1'b1)
            halt();
        chk("stack count", 40'd5, 40'(got.size()));
        r = {got[0], got[1], got[2], got[3]};
        chk("stack frame", {f[31:24], f[39:32], f[23:0]}, {r, got[4]});
        chk("vector", v, VEC_ADDR);
        chk("mask after entry", 1'b1, I_MASK);
        frm_q.push_back(f);
        im = 1'b1;
    endtask : take

    task return_from_trap_instr;
        logic [39:0] f;
        int          n;
        f = frm_q.pop_back();
        @(posedge CLK);
        RTI_EXEC <= 1'b1;
        @(posedge CLK);
        RTI_EXEC <= 1'b0;
        n = 0;
        while (RESTORE !== 1'b1 && n < 30)
        begin
            @(posedge CLK);
            n++;
        end
        if (RESTORE !== 1'b1)
            halt();
        chk("restored", f, {RST_PC, RST_X, RST_A, RST_CCR});
        chk("mask restore", f[cis_pkg::CCR_I_BIT], I_MASK);
        im = f[cis_pkg::CCR_I_BIT];
    endtask : return_from_trap_instr

    task swpush(input logic [39:0] f);
        logic [39:0] b;
        b = {f[31:24], f[39:32], f[23:0]};
        for (int i = 4; i >= 0; i--)
        begin
            @(posedge CLK);
            sw_push <= 1'b1;
            sw_byte <= b[i*8 +: 8];
        end
        @(posedge CLK);
        sw_push <= 1'b0;
        frm_q.push_back(f);
    endtask : swpush

    task clear(input logic [11:0] m);
        apb(1'b0, cis_pkg::OFS_FLAGS, 32'h0);
        chk("flags", 32'(m), rd);
        apb(1'b1, cis_pkg::OFS_ENABLE, 32'hfff);
        apb(1'b0, cis_pkg::OFS_FLAGS, 32'h0);
        chk("flags cleared", 32'h0, rd);
    endtask : clear

    function automatic logic [15:0] vec_of(input int i);
        case (i)
            0, 1:        return cis_pkg::VEC_EXT;
            2:           return cis_pkg::VEC_TIMER2;
            3, 4, 5:     return cis_pkg::VEC_TIMER1;
            6:           return cis_pkg::VEC_SERIAL;
            7, 8, 9, 10: return cis_pkg::VEC_CODER;
            default:     return cis_pkg::VEC_KEYPAD;
        endcase
    endfunction : vec_of

    initial
    begin
        seed = 51392;
        fails = 0;
        comparisons = 0;
        im = 1'b1;
        SRST = 1'b1;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {FLAG_EVT, INSTR_END, SWI_EXEC, RTI_EXEC} = '0;
        {CUR_PC, CUR_X, CUR_A, CUR_CCR, sw_push, sw_byte} = '0;
        repeat (16) @(posedge CLK);
        SRST <= 1'b0;
        chk("reset vector", cis_pkg::VEC_RESET, VEC_ADDR);
        apb(1'b0, cis_pkg::OFS_ENABLE, 32'h0);
        chk("enable reset", 32'(cis_pkg::ENABLE_RST), rd);
        apb(1'b1, cis_pkg::OFS_FLAGS, 32'hfff);
        apb(1'b0, cis_pkg::OFS_FLAGS, 32'h0);
        chk("flags read only", 32'h0, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 1'b1, er);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, cis_pkg::OFS_ENABLE, 32'hfff);
        apb(1'b1, cis_pkg::OFS_IMASK, 32'h7);
        evt(12'h001);
        no_take("mask blocks");
        take(1'b1, cis_pkg::VEC_SWI);
        return_from_trap_instr();
        swpush({16'h1234, 8'h56, 8'h78, 8'h00});
        return_from_trap_instr();
        clear(12'h001);
        for (int i = 0; i < 12; i++)
        begin
            apb(1'b0, cis_pkg::OFS_ISTAT, 32'h0);
            evt(12'h001 << i);
            take(1'b0, vec_of(i));
            repeat (2) @(posedge CLK);
            chk("irq raised", 1'b1, IRQ);
            apb(1'b0, cis_pkg::OFS_ISTAT, 32'h0);
            chk("istat", 32'h1, rd);
            repeat (2) @(posedge CLK);
            chk("irq cleared", 1'b0, IRQ);
            clear(12'h001 << i);
            return_from_trap_instr();
        end
        apb(1'b0, cis_pkg::OFS_ISTAT, 32'h0);
        apb(1'b1, cis_pkg::OFS_IMASK, 32'h6);
        evt(12'h804);
        repeat (4) @(posedge CLK);
        chk("boundary wait", 1'b0, BUSY);
        apb(1'b0, cis_pkg::OFS_STATE, 32'h0);
        chk("state", 32'(cis_pkg::GRP_TIMER2) << 4, rd);
        take(1'b0, cis_pkg::VEC_TIMER2);
        repeat (2) @(posedge CLK);
        chk("irq masked", 1'b0, IRQ);
        apb(1'b1, cis_pkg::OFS_IMASK, 32'h7);
        repeat (2) @(posedge CLK);
        chk("irq unmasked", 1'b1, IRQ);
        clear(12'h804);
        return_from_trap_instr();
        apb(1'b1, cis_pkg::OFS_ENABLE, 32'hfbf);
        evt(12'h040);
        no_take("disabled source");
        clear(12'h040);
        @(posedge CLK);
        SRST <= 1'b1;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        chk("mask reset", 1'b1, I_MASK);
        apb(1'b0, cis_pkg::OFS_ENABLE, 32'h0);
        chk("enable second reset", 32'h0, rd);
        results();
    end
endmodule : testbench
